// File: inc/prda_consts.vh
// constants for the panel reserved data area block
// assumes inclusion by bare name from the design file
`ifndef PRDA_CONSTS_VH
`define PRDA_CONSTS_VH

// word indices of the reserved area, byte address is four times these
`define PRDA_IDX_KEY0 6'h00
`define PRDA_IDX_KEY1 6'h01
`define PRDA_IDX_KEY2 6'h02
`define PRDA_IDX_KEY3 6'h03
`define PRDA_IDX_RTC_DOW 6'h04
`define PRDA_IDX_RTC_DM 6'h05
`define PRDA_IDX_RTC_YH 6'h06
`define PRDA_IDX_RTC_MS 6'h07
`define PRDA_IDX_STATUS 6'h08
`define PRDA_IDX_PAGE 6'h09
`define PRDA_IDX_LED_LO 6'h0F
`define PRDA_IDX_LED_HI 6'h10
`define PRDA_IDX_CTRL 6'h18

// key flag positions within the 64 key bits
`define PRDA_KEY_ENTER 36
`define PRDA_KEY_HELP 62
`define PRDA_KEY_CLEAR 63

// status word bit positions
`define PRDA_ST_HEARTBEAT 0
`define PRDA_ST_DATA_ENTRY 1
`define PRDA_ST_PRINTING 2
`define PRDA_ST_PRN_READY 3
`define PRDA_ST_CLK_UPD 4
`define PRDA_ST_PROTECTED 5
`define PRDA_ST_BATT_LOW 6
`define PRDA_ST_ALARM 7
`define PRDA_ST_UNACKED 8
`define PRDA_ST_BACKUP 12
`define PRDA_ST_UPLOAD 13
`define PRDA_ST_DOWNLOAD 14
`define PRDA_ST_FILE_BAD 15

// control register fields
`define PRDA_CTRL_BCD 0
`define PRDA_CTRL_USER_MAP 1
`define PRDA_CTRL_PROT_CLR 2

// reset values
`define PRDA_RST_CTRL 2'h0
`define PRDA_RST_LED 32'h00000000
`define PRDA_RST_WAIT 1'b1

// timing
`define PRDA_CLK_HZ 20000000
`define PRDA_HEARTBEAT_MS 1000

`endif

// File: design/prda_top.v
// panel reserved data area: key flags, status word, clock record,
// current page and led control, reached over avalon-mm with waitrequest
// assumes one 20 mhz clock; key, cts and battery pins are asynchronous,
// all other status inputs come from panel logic on clk_sys
`timescale 1ns/10ps
`include "prda_consts.vh"

module prda_top #(
  parameter integer HB_CYCLES = `PRDA_CLK_HZ / 1000 * `PRDA_HEARTBEAT_MS,
  parameter integer CNT_W = 25
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // key pins, high while pressed
  input wire [63:0] key_pin,
  input wire enter_key_pin,
  input wire help_key_pin,
  input wire clear_key_pin,
  // other pins
  input wire printer_cts_pin,
  input wire battery_weak_pin,
  // panel state from local logic
  input wire link_ok,
  input wire data_entry_mode,
  input wire page_mode,
  input wire printing,
  input wire protected_attempt,
  input wire alarm_any,
  input wire unacked_any,
  input wire backup_busy,
  input wire recipe_upload,
  input wire recipe_download,
  input wire recipe_bad,
  input wire [15:0] page_number,
  // clock record load
  input wire rtc_load,
  input wire rtc_sec_only,
  input wire [7:0] rtc_dow,
  input wire [7:0] rtc_day,
  input wire [7:0] rtc_month,
  input wire [7:0] rtc_year,
  input wire [7:0] rtc_hour,
  input wire [7:0] rtc_minute,
  input wire [7:0] rtc_second,
  output reg rtc_busy_q,
  // led drive
  output reg [15:0] fkey_led_q,
  output reg [9:0] numeric_led_q,
  output reg sign_led_q,
  output reg [7:0] user_led_q
);

  localparam integer NSYNC = 66;
  localparam integer HB_LAST_I = HB_CYCLES - 1;
  localparam [CNT_W-1:0] HB_LAST = HB_LAST_I[CNT_W-1:0];
  localparam [1:0] RTC_IDLE = 2'h0;
  localparam [1:0] RTC_FLAG = 2'h1;
  localparam [1:0] RTC_WRITE = 2'h2;
  localparam [1:0] RTC_CLEAR = 2'h3;

  // binary to four bcd digits; values above 9999 wrap in the top digit
  function [15:0] prda_to_bcd;
    input [15:0] bin;
    integer i;
    integer j;
    reg [31:0] sh;
    begin
      sh = {16'h0000, bin};
      for (i = 0; i < 16; i = i + 1) begin
        for (j = 0; j < 4; j = j + 1) begin
          if (sh[16 + 4 * j +: 4] > 4'h4) begin
            sh[16 + 4 * j +: 4] = sh[16 + 4 * j +: 4] + 4'h3;
          end
        end
        sh = sh << 1;
      end
      prda_to_bcd = sh[31:16];
    end
  endfunction

  // named keys take their fixed places in the key flag field
  wire [63:0] key_all;
  assign key_all = {clear_key_pin, help_key_pin, key_pin[61:37], enter_key_pin,
    key_pin[35:0]};

  wire [NSYNC-1:0] pin_raw;
  assign pin_raw = {battery_weak_pin, printer_cts_pin, key_all};

  reg [NSYNC-1:0] pin_s1_q;
  reg [NSYNC-1:0] pin_s2_q;
  reg [NSYNC-1:0] pin_s3_q;
  reg [NSYNC-1:0] pin_q;

  // three stage synchroniser per pin; a change counts when the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          pin_s1_q[g] <= 1'b0;
          pin_s2_q[g] <= 1'b0;
          pin_s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          pin_s1_q[g] <= pin_raw[g];
          pin_s2_q[g] <= pin_s1_q[g];
          pin_s3_q[g] <= pin_s2_q[g];
          if (pin_s2_q[g] == pin_s3_q[g]) begin
            pin_q[g] <= pin_s3_q[g];
          end
        end
      end
    end
  endgenerate

  wire [63:0] key_flags;
  wire cts_q;
  wire batt_q;
  assign key_flags = pin_q[63:0];
  assign cts_q = pin_q[64];
  assign batt_q = pin_q[65];

  // heartbeat divider, only runs while the link is up
  reg [CNT_W-1:0] hb_cnt_q;
  reg hb_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hb_cnt_q <= {CNT_W{1'b0}};
      hb_q <= 1'b0;
    end else if (!link_ok) begin
      hb_cnt_q <= {CNT_W{1'b0}}; // a stalled bit tells the controller
    end else if (hb_cnt_q == HB_LAST) begin
      hb_cnt_q <= {CNT_W{1'b0}};
      hb_q <= ~hb_q;
    end else begin
      hb_cnt_q <= hb_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // clock record: full loads are staged so fields change only under the flag; seconds-only loads write sec_q at once
  reg [1:0] rtc_st_q;
  reg clk_flag_q;
  reg [7:0] stg_dow_q, stg_day_q, stg_mon_q, stg_year_q;
  reg [7:0] stg_hour_q, stg_min_q, stg_sec_q;
  reg [7:0] dow_q, day_q, mon_q, year_q, hour_q, min_q, sec_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rtc_st_q <= RTC_IDLE;
      clk_flag_q <= 1'b0;
      rtc_busy_q <= 1'b0;
      stg_dow_q <= 8'h00;
      stg_day_q <= 8'h00;
      stg_mon_q <= 8'h00;
      stg_year_q <= 8'h00;
      stg_hour_q <= 8'h00;
      stg_min_q <= 8'h00;
      stg_sec_q <= 8'h00;
      dow_q <= 8'h00;
      day_q <= 8'h00;
      mon_q <= 8'h00;
      year_q <= 8'h00;
      hour_q <= 8'h00;
      min_q <= 8'h00;
      sec_q <= 8'h00;
    end else begin
      case (rtc_st_q)
        RTC_IDLE: begin
          if (rtc_load && rtc_sec_only) begin
            sec_q <= rtc_second; // flag stays down
          end else if (rtc_load) begin
            stg_dow_q <= rtc_dow;
            stg_day_q <= rtc_day;
            stg_mon_q <= rtc_month;
            stg_year_q <= rtc_year;
            stg_hour_q <= rtc_hour;
            stg_min_q <= rtc_minute;
            stg_sec_q <= rtc_second;
            rtc_busy_q <= 1'b1;
            rtc_st_q <= RTC_FLAG;
          end
        end
        RTC_FLAG: begin
          clk_flag_q <= 1'b1;
          rtc_st_q <= RTC_WRITE;
        end
        RTC_WRITE: begin
          dow_q <= stg_dow_q;
          day_q <= stg_day_q;
          mon_q <= stg_mon_q;
          year_q <= stg_year_q;
          hour_q <= stg_hour_q;
          min_q <= stg_min_q;
          sec_q <= stg_sec_q;
          rtc_st_q <= RTC_CLEAR;
        end
        RTC_CLEAR: begin
          clk_flag_q <= 1'b0;
          rtc_busy_q <= 1'b0;
          rtc_st_q <= RTC_IDLE;
        end
        default: begin
          clk_flag_q <= 1'b0;
          rtc_busy_q <= 1'b0;
          rtc_st_q <= RTC_IDLE;
        end
      endcase
    end
  end

  // bus handshake: request seen -> waitrequest low one cycle
  wire req;
  wire bus_commit;
  wire [5:0] idx;
  assign req = avs_read | avs_write;
  assign bus_commit = avs_write & ~avs_waitrequest;
  assign idx = avs_address[7:2];

  // control and led registers written by the controller
  reg [1:0] ctrl_q;
  reg [31:0] led_q;
  wire ctrl_wr;
  wire led_lo_wr;
  wire led_hi_wr;
  wire prot_clr;
  assign ctrl_wr = bus_commit && (idx == `PRDA_IDX_CTRL) && avs_byteenable[0];
  assign led_lo_wr = bus_commit && (idx == `PRDA_IDX_LED_LO);
  assign led_hi_wr = bus_commit && (idx == `PRDA_IDX_LED_HI);
  assign prot_clr = ctrl_wr && avs_writedata[`PRDA_CTRL_PROT_CLR];

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `PRDA_RST_CTRL;
      led_q <= `PRDA_RST_LED;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= avs_writedata[1:0];
      end
      if (led_lo_wr && avs_byteenable[0]) begin
        led_q[7:0] <= avs_writedata[7:0];
      end
      if (led_lo_wr && avs_byteenable[1]) begin
        led_q[15:8] <= avs_writedata[15:8];
      end
      if (led_hi_wr && avs_byteenable[0]) begin
        led_q[23:16] <= avs_writedata[7:0];
      end
      if (led_hi_wr && avs_byteenable[1]) begin
        led_q[31:24] <= avs_writedata[15:8];
      end
    end
  end

  // protected access is sticky; a new attempt beats a clear
  reg prot_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prot_q <= 1'b0;
    end else if (protected_attempt) begin
      prot_q <= 1'b1;
    end else if (prot_clr) begin
      prot_q <= 1'b0;
    end
  end

  // status word, rebuilt every cycle from live state
  reg [15:0] status_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= 16'h0000; // bits 9 to 11 never set
      status_q[`PRDA_ST_HEARTBEAT] <= hb_q;
      status_q[`PRDA_ST_DATA_ENTRY] <= data_entry_mode;
      status_q[`PRDA_ST_PRINTING] <= printing;
      status_q[`PRDA_ST_PRN_READY] <= cts_q;
      status_q[`PRDA_ST_CLK_UPD] <= clk_flag_q;
      status_q[`PRDA_ST_PROTECTED] <= prot_q | protected_attempt;
      status_q[`PRDA_ST_BATT_LOW] <= batt_q;
      status_q[`PRDA_ST_ALARM] <= alarm_any;
      status_q[`PRDA_ST_UNACKED] <= unacked_any;
      status_q[`PRDA_ST_BACKUP] <= backup_busy;
      status_q[`PRDA_ST_UPLOAD] <= recipe_upload;
      status_q[`PRDA_ST_DOWNLOAD] <= recipe_download;
      status_q[`PRDA_ST_FILE_BAD] <= recipe_bad;
    end
  end

  // current page, coded as the attached controller expects
  reg [15:0] page_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      page_q <= 16'h0000;
    end else if (page_mode || data_entry_mode) begin
      if (ctrl_q[`PRDA_CTRL_BCD]) begin
        page_q <= prda_to_bcd(page_number);
      end else begin
        page_q <= page_number;
      end
    end else begin
      page_q <= 16'h0000;
    end
  end

  // read mux; unmapped words read zero and ignore writes
  reg [15:0] rd_mux;
  always @* begin
    case (idx)
      `PRDA_IDX_KEY0: rd_mux = key_flags[15:0];
      `PRDA_IDX_KEY1: rd_mux = key_flags[31:16];
      `PRDA_IDX_KEY2: rd_mux = key_flags[47:32];
      `PRDA_IDX_KEY3: rd_mux = key_flags[63:48];
      `PRDA_IDX_RTC_DOW: rd_mux = {8'h00, dow_q};
      `PRDA_IDX_RTC_DM: rd_mux = {day_q, mon_q};
      `PRDA_IDX_RTC_YH: rd_mux = {year_q, hour_q};
      `PRDA_IDX_RTC_MS: rd_mux = {min_q, sec_q};
      `PRDA_IDX_STATUS: rd_mux = status_q;
      `PRDA_IDX_PAGE: rd_mux = page_q;
      `PRDA_IDX_LED_LO: rd_mux = led_q[15:0];
      `PRDA_IDX_LED_HI: rd_mux = led_q[31:16];
      `PRDA_IDX_CTRL: rd_mux = {14'h0000, ctrl_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // one wait state: data is latched and stands while waitrequest is low
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= `PRDA_RST_WAIT;
      avs_readdata <= 32'h00000000;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? {16'h0000, rd_mux} : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // led drive; the map follows the user map bit of the control register
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fkey_led_q <= 16'h0000;
      numeric_led_q <= 10'h000;
      sign_led_q <= 1'b0;
      user_led_q <= 8'h00;
    end else if (ctrl_q[`PRDA_CTRL_USER_MAP]) begin
      fkey_led_q <= led_q[15:0];
      numeric_led_q <= 10'h000;
      sign_led_q <= 1'b0;
      user_led_q <= led_q[31:24];
    end else begin
      fkey_led_q <= led_q[15:0];
      numeric_led_q <= led_q[25:16];
      sign_led_q <= led_q[27];
      user_led_q <= 8'h00;
    end
  end

endmodule // prda_top

// File: verification/prda_plc_model.sv
// controller model: avalon master reaching the shared area
// assumes one caller at a time, tasks entered just after a clock edge
`timescale 1ns/10ps
module prda_plc_model (
  // clock
  input wire clk_sys,
  // avalon master
  output logic [7:0] avs_address = 8'h00,
  output logic avs_read = 1'h0,
  output logic avs_write = 1'h0,
  output logic [31:0] avs_writedata = 32'h0,
  output logic [3:0] avs_byteenable = 4'h0,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  // one transfer held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [5:0] i, input logic [15:0] d,
    input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= {i, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    // idle lines must not pass for a held request
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask
  // a link bit that never moves over the window means a dead panel
  task automatic hb_seen(input int n, output logic ok);
    logic [31:0] a;
    logic [31:0] b;
    xfer(1'h0, 6'h08, 16'h0, 4'hF, a);
    ok = 1'h0;
    repeat (n) begin
      xfer(1'h0, 6'h08, 16'h0, 4'hF, b);
      if (b[0] !== a[0]) ok = 1'h1;
      a = b;
    end
  endtask
  // clock fields are only trusted when the update flag reads clear
  task automatic rd_clock(output logic [63:0] f, output logic ok);
    logic [31:0] q;
    xfer(1'h0, 6'h08, 16'h0, 4'hF, q);
    ok = !q[4];
    for (int i = 4; i < 8; i++) begin
      xfer(1'h0, i[5:0], 16'h0, 4'hF, q);
      f = {f[47:0], q[15:0]};
    end
  endtask
endmodule // prda_plc_model

// File: verification/prda_chk.sv
// checker for prda_top: bus handshake, clock record, led drive, page
// assumes bind into prda_top, one clock domain
`timescale 1ns/10ps
module prda_chk (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // panel side
  input wire page_mode,
  input wire data_entry_mode,
  input wire rtc_load,
  input wire rtc_sec_only,
  input wire rtc_busy_q,
  input wire [15:0] fkey_led_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire ack = !avs_waitrequest;
  wire [5:0] idx = avs_address[7:2];
  wire led_wr = avs_write && ack && idx == 6'h0F;
  logic [15:0] led_d_q;
  // keep the written word, the bus drops it right after the ack
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) led_d_q <= 16'h0000;
    else if (led_wr) led_d_q <= avs_writedata[15:0];
  end
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> ack ##1 avs_waitrequest)
    else $error("ack not exactly one cycle");
  a_no_ack: assert property (
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("ack without request");
  a_upper_zero: assert property (ack |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_rsvd_zero: assert property (
    avs_read && ack && idx == 6'h08 |-> avs_readdata[11:9] == 3'h0)
    else $error("reserved status bits set");
  a_rtc_seq: assert property (
    rtc_load && !rtc_busy_q && !rtc_sec_only |=> rtc_busy_q [*3] ##1 !rtc_busy_q)
    else $error("clock record sequence wrong");
  a_sec_only: assert property (
    rtc_load && !rtc_busy_q && rtc_sec_only |=> !rtc_busy_q)
    else $error("seconds update ran full sequence");
  a_led_drive: assert property (led_wr |-> ##[1:2] fkey_led_q == led_d_q)
    else $error("function key leds not driven");
  a_page_zero: assert property (
    (!(page_mode || data_entry_mode)) [*3] ##0 (avs_read && ack && idx == 6'h09)
    |-> avs_readdata[15:0] == 16'h0000) else $error("page not zero");
  c_read: cover property (avs_read && ack);
  c_full: cover property (rtc_load && !rtc_busy_q && !rtc_sec_only);
  c_sec: cover property (rtc_load && !rtc_busy_q && rtc_sec_only);
endmodule // prda_chk

bind prda_top prda_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .page_mode(page_mode),
  .data_entry_mode(data_entry_mode), .rtc_load(rtc_load),
  .rtc_sec_only(rtc_sec_only), .rtc_busy_q(rtc_busy_q), .fkey_led_q(fkey_led_q));

// File: verification/test_panel_reserved_data_area.sv
// bench for the panel reserved data area: bus, status, keys, leds, clock
// assumes the design, the controller model and the checker bind alongside
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin n_fail++; \
  $display("BAD %s exp %h seen %h", n, e, s); end end
module test_panel_reserved_data_area;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic [10:0] st = 11'h0;
  logic [15:0] pg = 16'h0;
  logic [63:0] kp = 64'h0;
  logic [2:0] ek = 3'h0;
  logic [55:0] rf = 56'h0;
  logic pa = 1'h0;
  logic lk = 1'h1;
  logic rl = 1'h0;
  logic ss = 1'h0;
  int compares = 0;
  int n_fail = 0;
  wire [7:0] adr;
  wire rd;
  wire wr;
  wire [31:0] wd;
  wire [3:0] be;
  wire [31:0] rdat;
  wire wt;
  wire [15:0] fled;
  wire [9:0] nled;
  wire sled;
  wire [7:0] uled;
  // enter, help and clear pins take over their three key flags
  wire [63:0] kexp = {ek[2], ek[1], kp[61:37], ek[0], kp[35:0]};
  // short link period so the heartbeat shows within a few reads
  prda_top #(.HB_CYCLES(16), .CNT_W(25)) u_prda_top (.clk_sys(clk_sys),
    .reset_n(reset_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt), .key_pin(kp), .enter_key_pin(ek[0]),
    .help_key_pin(ek[1]), .clear_key_pin(ek[2]), .printer_cts_pin(st[2]),
    .battery_weak_pin(st[3]), .link_ok(lk), .data_entry_mode(st[0]),
    .page_mode(st[10]), .printing(st[1]), .protected_attempt(pa),
    .alarm_any(st[4]), .unacked_any(st[5]), .backup_busy(st[6]),
    .recipe_upload(st[7]), .recipe_download(st[8]), .recipe_bad(st[9]),
    .page_number(pg), .rtc_load(rl), .rtc_sec_only(ss), .rtc_dow(rf[55:48]),
    .rtc_day(rf[47:40]), .rtc_month(rf[39:32]), .rtc_year(rf[31:24]),
    .rtc_hour(rf[23:16]), .rtc_minute(rf[15:8]), .rtc_second(rf[7:0]),
    .rtc_busy_q(), .fkey_led_q(fled), .numeric_led_q(nled), .sign_led_q(sled),
    .user_led_q(uled));
  prda_plc_model u_plc (.clk_sys(clk_sys), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wt));
  always #25 clk_sys = ~clk_sys;
  // status word as expected, link bit masked since it moves by itself
  function automatic logic [15:0] exp_st(input logic [10:0] s);
    exp_st = {s[9:6], 3'h0, s[5:3], 2'h0, s[2:0], 1'h0};
  endfunction
  // page zero outside page and entry modes; bcd only meaningful below 10000
  function automatic logic [15:0] exp_pg(input logic [10:0] s,
    input logic [15:0] p, input logic bcd);
    exp_pg = !(s[0] || s[10]) ? 16'h0 : !bcd ? p : {4'(p / 16'h03E8),
      4'(p / 16'h0064 % 16'h000A), 4'(p / 16'h000A % 16'h000A), 4'(p % 16'h000A)};
  endfunction
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the roughly one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up;
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] ld;
    logic [63:0] f;
    logic [63:0] ef;
    logic ok;
    int seed;
    seed = 32'hC8164A43;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'h1;
    // unmapped write refused, led words come up clear
    u_plc.xfer(1'h1, 6'h0A, 16'hFFFF, 4'h3, q);
    for (int i = 0; i < 3; i++) begin
      u_plc.xfer(1'h0, i == 0 ? 6'h0A : 6'h0E + i[5:0], 16'h0, 4'hF, q);
      `CHK("reset word", 32'h0, q)
    end
    // sticky protected bit, cleared by the controller's write-one
    pa <= 1'h1;
    @(posedge clk_sys);
    pa <= 1'h0;
    repeat (2) @(posedge clk_sys);
    u_plc.xfer(1'h0, 6'h08, 16'h0, 4'hF, q);
    `CHK("protected set", 1'h1, q[5])
    u_plc.xfer(1'h1, 6'h18, 16'h0004, 4'h1, q);
    u_plc.xfer(1'h0, 6'h08, 16'h0, 4'hF, q);
    `CHK("protected clr", 1'h0, q[5])
    // full record, second load while busy must be ignored
    rf <= 56'({$random(seed), $random(seed)});
    rl <= 1'h1;
    @(posedge clk_sys);
    ef = {8'h00, rf};
    rf <= ~rf;
    @(posedge clk_sys);
    rl <= 1'h0;
    // status read lands while the record is being rewritten
    u_plc.xfer(1'h0, 6'h08, 16'h0, 4'hF, q);
    `CHK("clock flag", 1'h1, q[4])
    repeat (6) @(posedge clk_sys);
    u_plc.rd_clock(f, ok);
    `CHK("clock idle", 1'h1, ok)
    `CHK("clock record", ef, f)
    // seconds-only update touches the seconds field alone
    rf[7:0] <= 8'h5A;
    {rl, ss} <= 2'h3;
    @(posedge clk_sys);
    {rl, ss} <= 2'h0;
    ef[7:0] = 8'h5A;
    repeat (3) @(posedge clk_sys);
    u_plc.rd_clock(f, ok);
    `CHK("seconds only", ef, f)
    // link bit moves while the link is up and freezes when it drops
    u_plc.hb_seen(12, ok);
    `CHK("link moving", 1'h1, ok)
    lk <= 1'h0;
    u_plc.hb_seen(12, ok);
    `CHK("link frozen", 1'h0, ok)
    lk <= 1'h1;
    // random panel state, keys and leds under each coding and led map
    for (int c = 0; c < 4; c++) begin
      u_plc.xfer(1'h1, 6'h18, 16'(c), 4'h1, q);
      repeat (6) begin
        st <= 11'($random(seed));
        pg <= 16'({$random(seed)} % 32'h2710);
        kp <= {$random(seed), $random(seed)};
        ek <= 3'($random(seed));
        ld = $random(seed);
        repeat (6) @(posedge clk_sys);
        u_plc.xfer(1'h1, 6'h08, 16'hFFFF, 4'h3, q);
        u_plc.xfer(1'h0, 6'h08, 16'h0, 4'hF, q);
        `CHK("status", exp_st(st), q[15:0] & 16'hFFFE)
        u_plc.xfer(1'h0, 6'h09, 16'h0, 4'hF, q);
        `CHK("page", exp_pg(st, pg, c[0]), q[15:0])
        for (int k = 0; k < 4; k++) begin
          u_plc.xfer(1'h0, k[5:0], 16'h0, 4'hF, q);
          `CHK("keys", kexp[k*16 +: 16], q[15:0])
        end
        u_plc.xfer(1'h1, 6'h0F, ld[15:0], 4'h3, q);
        u_plc.xfer(1'h1, 6'h10, ld[31:16], 4'h3, q);
        repeat (2) @(posedge clk_sys);
        `CHK("fkey led", ld[15:0], fled)
        if (c[1]) `CHK("user led", ld[31:24], uled)
        else `CHK("num led", {ld[27], ld[25:16]}, {sled, nled})
      end
    end
    wrap_up;
  end
endmodule // test_panel_reserved_data_area
